// *** pwr_seq_consts.svh ***
// Timing and clock constants shared by both ends of the power and reset link.
`ifndef PWR_SEQ_CONSTS_SVH
`define PWR_SEQ_CONSTS_SVH

`define SYS_CLK_HZ        25000000
`define CNT_W             26
`define PON_ASSERT_MS     25
`define RST_ASSERT_MS     20
`define POWER_UP_MS       2000
`define FAST_CLK_HZ       26000000
`define SLOW_CLK_HZ       32768
`define NCO_W             32

// Least times round up to whole cycles.
`define PON_ASSERT_CYC 26'((64'd`PON_ASSERT_MS * 64'd`SYS_CLK_HZ + 64'd999) / 64'd1000)
`define RST_ASSERT_CYC 26'((64'd`RST_ASSERT_MS * 64'd`SYS_CLK_HZ + 64'd999) / 64'd1000)
`define POWER_UP_CYC   26'((64'd`POWER_UP_MS * 64'd`SYS_CLK_HZ + 64'd999) / 64'd1000)
`define SLOW_NCO_INC   32'((64'd`SLOW_CLK_HZ << 32) / 64'd`SYS_CLK_HZ)

`endif

// *** pwr_seq_pkg.sv ***
// Types shared by both ends of the power and reset link.
`default_nettype none
package pwr_seq_pkg;

  typedef enum logic [1:0] {
    DEV_OFF  = 2'b00,
    DEV_BOOT = 2'b01,
    DEV_ON   = 2'b10
  } dev_state_e;

  typedef enum logic [1:0] {
    HOST_IDLE     = 2'b00,
    HOST_PON_HOLD = 2'b01,
    HOST_RST_HOLD = 2'b10,
    HOST_WAIT_UP  = 2'b11
  } host_state_e;

  typedef enum logic {
    CLK_SEL_FAST = 1'b0,
    CLK_SEL_SLOW = 1'b1
  } clk_sel_e;

endpackage : pwr_seq_pkg
`default_nettype wire

// *** pwr_link_if.sv ***
// Link between the host controller and the module power and reset sequencer.
`default_nettype none
interface pwr_link_if;
  logic                  powerOnRequestNOut;
  logic                  powerOnRequestNOe;
  logic                  powerOnPullUp;
  logic                  powerOnRequestN;
  logic                  resetRequestNOut;
  logic                  resetRequestNOe;
  logic                  resetPullUp;
  logic                  resetRequestN;
  logic                  ioSupplyStatus;
  logic                  fastClockOut;
  logic                  slowClockOut;
  logic                  shutdownCommand;
  logic                  clkCmdValid;
  pwr_seq_pkg::clk_sel_e clkCmdSel;
  logic                  clkCmdEnable;

  // Open-drain wires: a driven low wins, otherwise the device pull-up decides.
  assign powerOnRequestN = !(powerOnRequestNOe && !powerOnRequestNOut) && powerOnPullUp;
  assign resetRequestN   = !(resetRequestNOe && !resetRequestNOut) && resetPullUp;

  modport device (
    input  powerOnRequestN,
    input  resetRequestN,
    input  shutdownCommand,
    input  clkCmdValid,
    input  clkCmdSel,
    input  clkCmdEnable,
    output powerOnPullUp,
    output resetPullUp,
    output ioSupplyStatus,
    output fastClockOut,
    output slowClockOut
  );

  modport host (
    output powerOnRequestNOut,
    output powerOnRequestNOe,
    output resetRequestNOut,
    output resetRequestNOe,
    output shutdownCommand,
    output clkCmdValid,
    output clkCmdSel,
    output clkCmdEnable,
    input  powerOnRequestN,
    input  resetRequestN,
    input  ioSupplyStatus,
    input  fastClockOut,
    input  slowClockOut
  );
endinterface : pwr_link_if
`default_nettype wire

// *** module_power_reset_sequencer.sv ***
// Device end: power-on, reset and shutdown sequencing with two clock outputs.
//
// Behaviour
// - Valid low power-on request switches device on.
// - Host holds power-on request low 25 ms.
// - Power-up takes at least 2000 ms.
// - Device pulls power-on request high when supplied.
// - Power-on request never switches device off.
// - Status output low when off, high when on.
// - Host pulses reset request low 20 ms.
// - Valid reset with power-on low restarts.
// - Valid reset with power-on high powers off.
// - Reset clears processor registers and memory.
// - After reset, operational again after 2000 ms.
// - Host only pulls requests low or releases.
// - Provide fast and slow clock outputs.
// - Clock outputs change only by command (code also stops them while off and resumes them at power-on).
// - Host may release power-on after detection.
`include "pwr_seq_consts.svh"
`default_nettype none
module module_power_reset_sequencer #(
  parameter logic [`CNT_W-1:0] PonAssertCyc = `PON_ASSERT_CYC,
  parameter logic [`CNT_W-1:0] RstAssertCyc = `RST_ASSERT_CYC,
  parameter logic [`CNT_W-1:0] PowerUpCyc   = `POWER_UP_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       mainSupplyOk,
  input  wire logic       alwaysOnSupplyOk,
  pwr_link_if.device      link,
  output logic            coreRun,
  output logic            memoryClear,
  output logic            poweredUp
);

  // ==========================================================================
  // State
  // ==========================================================================
  pwr_seq_pkg::dev_state_e state_r, state_nxt;
  logic [`CNT_W-1:0] bootCnt_r, bootCnt_nxt;
  logic              fastEn_r, fastEn_nxt;
  logic              slowEn_r, slowEn_nxt;
  logic              clear_r, clear_nxt;
  logic              ponFire;
  logic              rstFire;
  logic [1:0]        reqPinN;
  logic [1:0]        reqFire;

  // ==========================================================================
  // Request filters, power-on first and reset second
  // ==========================================================================
  assign reqPinN = {link.resetRequestN, link.powerOnRequestN};

  for (genvar i = 0; i < 2; i++) begin : g_req
    localparam logic [`CNT_W-1:0] MinLow = (i == 0) ? PonAssertCyc : RstAssertCyc;
    logic [`CNT_W-1:0] lowCnt_r, lowCnt_nxt;

    // Counters restart on every high level, so short pulses leave no trace.
    always_comb begin
      if (reqPinN[i]) begin
        lowCnt_nxt = '0;
      end else if (lowCnt_r != MinLow) begin
        lowCnt_nxt = lowCnt_r + 1'b1;
      end else begin
        lowCnt_nxt = lowCnt_r;
      end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        lowCnt_r <= '0;
      end else if (ce) begin
        lowCnt_r <= lowCnt_nxt;
      end
    end

    // A request counts only on the cycle its low level reaches the least time.
    assign reqFire[i] = !reqPinN[i] && (lowCnt_r == MinLow - 1'b1);
  end

  // The counter saturates, so a held pin fires once until it is released.
  assign ponFire = reqFire[0];
  assign rstFire = reqFire[1];

  // ==========================================================================
  // Power state
  // ==========================================================================

  always_comb begin
    state_nxt   = state_r;
    bootCnt_nxt = bootCnt_r;
    fastEn_nxt  = fastEn_r;
    slowEn_nxt  = slowEn_r;
    clear_nxt   = 1'b0;
    unique case (state_r)
      pwr_seq_pkg::DEV_OFF: begin
        if (ponFire) begin
          state_nxt   = pwr_seq_pkg::DEV_BOOT;
          bootCnt_nxt = '0;
        end
      end
      pwr_seq_pkg::DEV_BOOT: begin
        bootCnt_nxt = bootCnt_r + 1'b1;
        if (bootCnt_r == PowerUpCyc - 1'b1) begin
          state_nxt = pwr_seq_pkg::DEV_ON;
        end
      end
      pwr_seq_pkg::DEV_ON: begin
        // The power-on request is not looked at here; the shutdown command or a valid reset request below ends the on state.
        if (link.shutdownCommand) begin
          state_nxt = pwr_seq_pkg::DEV_OFF;
        end
      end
      default: begin
        state_nxt = pwr_seq_pkg::DEV_OFF;
      end
    endcase
    if (rstFire) begin
      clear_nxt = 1'b1;
      if (!link.powerOnRequestN) begin
        state_nxt   = pwr_seq_pkg::DEV_BOOT;
        bootCnt_nxt = '0;
      end else begin
        state_nxt = pwr_seq_pkg::DEV_OFF;
      end
    end
    if (link.clkCmdValid && state_r == pwr_seq_pkg::DEV_ON) begin
      if (link.clkCmdSel == pwr_seq_pkg::CLK_SEL_FAST) begin
        fastEn_nxt = link.clkCmdEnable;
      end else begin
        slowEn_nxt = link.clkCmdEnable;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= pwr_seq_pkg::DEV_OFF;
      bootCnt_r <= '0;
      fastEn_r  <= 1'b0;
      slowEn_r  <= 1'b0;
      clear_r   <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      bootCnt_r <= bootCnt_nxt;
      fastEn_r  <= fastEn_nxt;
      slowEn_r  <= slowEn_nxt;
      clear_r   <= clear_nxt;
    end
  end

  // ==========================================================================
  // Outputs and clock generation
  // ==========================================================================
  logic [`NCO_W-1:0] slowAcc_r, slowAcc_nxt;
  logic              fastClk_r, fastClk_nxt;
  logic              slowClk_r, slowClk_nxt;
  logic              status_r, status_nxt;
  logic              ponPull_r, ponPull_nxt;
  logic              rstPull_r, rstPull_nxt;
  logic              coreRun_r, coreRun_nxt;
  logic              poweredUp_r, poweredUp_nxt;

  always_comb begin
    status_nxt    = (state_nxt != pwr_seq_pkg::DEV_OFF);
    coreRun_nxt   = (state_nxt == pwr_seq_pkg::DEV_ON);
    poweredUp_nxt = coreRun_nxt;
    ponPull_nxt   = mainSupplyOk;
    rstPull_nxt   = alwaysOnSupplyOk;
    // The slow output is the top bit of a phase accumulator, so its period jitters by a cycle.
    slowAcc_nxt   = slowAcc_r + `SLOW_NCO_INC;
    // The fast output toggles every cycle, the fastest this clock can make.
    fastClk_nxt   = (fastEn_r && status_nxt) ? !fastClk_r : 1'b0;
    slowClk_nxt   = (slowEn_r && status_nxt) ? slowAcc_nxt[`NCO_W-1] : 1'b0;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slowAcc_r   <= '0;
      fastClk_r   <= 1'b0;
      slowClk_r   <= 1'b0;
      status_r    <= 1'b0;
      ponPull_r   <= 1'b0;
      rstPull_r   <= 1'b0;
      coreRun_r   <= 1'b0;
      poweredUp_r <= 1'b0;
    end else if (ce) begin
      slowAcc_r   <= slowAcc_nxt;
      fastClk_r   <= fastClk_nxt;
      slowClk_r   <= slowClk_nxt;
      status_r    <= status_nxt;
      ponPull_r   <= ponPull_nxt;
      rstPull_r   <= rstPull_nxt;
      coreRun_r   <= coreRun_nxt;
      poweredUp_r <= poweredUp_nxt;
    end
  end

  assign link.ioSupplyStatus = status_r;
  assign link.fastClockOut   = fastClk_r;
  assign link.slowClockOut   = slowClk_r;
  assign link.powerOnPullUp  = ponPull_r;
  assign link.resetPullUp    = rstPull_r;
  assign coreRun             = coreRun_r;
  assign memoryClear         = clear_r;
  assign poweredUp           = poweredUp_r;

endmodule : module_power_reset_sequencer
`default_nettype wire

// *** power_request_host.sv ***
// Host end: drives power-on, reset, shutdown and clock commands to the module.
`include "pwr_seq_consts.svh"
`default_nettype none
module power_request_host #(
  parameter logic [`CNT_W-1:0] PonAssertCyc = `PON_ASSERT_CYC,
  parameter logic [`CNT_W-1:0] RstAssertCyc = `RST_ASSERT_CYC,
  parameter logic [`CNT_W-1:0] PowerUpCyc   = `POWER_UP_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic                  powerOnStart,
  input  wire logic                  resetStart,
  input  wire logic                  resetRestart,
  input  wire logic                  shutdownStart,
  input  wire logic                  clkCmdStart,
  input  wire pwr_seq_pkg::clk_sel_e clkSel,
  input  wire logic                  clkEnable,
  pwr_link_if.host                   link,
  output logic                       busy,
  output logic                       moduleOn,
  output logic                       moduleReady
);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  pwr_seq_pkg::host_state_e state_r, state_nxt;
  logic [`CNT_W-1:0]     cnt_r, cnt_nxt;
  logic                  ponOe_r, ponOe_nxt;
  logic                  rstOe_r, rstOe_nxt;
  logic                  shut_r, shut_nxt;
  logic                  cmdValid_r, cmdValid_nxt;
  pwr_seq_pkg::clk_sel_e cmdSel_r, cmdSel_nxt;
  logic                  cmdEn_r, cmdEn_nxt;
  logic                  busy_r, busy_nxt;
  logic                  on_r, on_nxt;
  logic                  ready_r, ready_nxt;
  logic                  idle;

  assign idle = (state_r == pwr_seq_pkg::HOST_IDLE);

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    ponOe_nxt    = ponOe_r;
    rstOe_nxt    = rstOe_r;
    ready_nxt    = ready_r && link.ioSupplyStatus;
    shut_nxt     = idle && shutdownStart && !powerOnStart && !resetStart;
    cmdValid_nxt = idle && clkCmdStart && !shutdownStart && !powerOnStart && !resetStart;
    cmdSel_nxt   = clkSel;
    cmdEn_nxt    = clkEnable;
    unique case (state_r)
      pwr_seq_pkg::HOST_IDLE: begin
        if (resetStart) begin
          state_nxt = pwr_seq_pkg::HOST_RST_HOLD;
          cnt_nxt   = '0;
          rstOe_nxt = 1'b1;
          ponOe_nxt = resetRestart;
          ready_nxt = 1'b0;
        end else if (powerOnStart) begin
          state_nxt = pwr_seq_pkg::HOST_PON_HOLD;
          cnt_nxt   = '0;
          ponOe_nxt = 1'b1;
        end else if (shutdownStart) begin
          ready_nxt = 1'b0;
        end
      end
      pwr_seq_pkg::HOST_PON_HOLD: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == PonAssertCyc - 1'b1) begin
          ponOe_nxt = 1'b0;
          state_nxt = pwr_seq_pkg::HOST_WAIT_UP;
        end
      end
      pwr_seq_pkg::HOST_RST_HOLD: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == RstAssertCyc - 1'b1) begin
          rstOe_nxt = 1'b0;
          ponOe_nxt = 1'b0;
          state_nxt = ponOe_r ? pwr_seq_pkg::HOST_WAIT_UP : pwr_seq_pkg::HOST_IDLE;
        end
      end
      pwr_seq_pkg::HOST_WAIT_UP: begin
        // Counting continues from the falling edge of the request.
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == PowerUpCyc - 1'b1) begin
          state_nxt = pwr_seq_pkg::HOST_IDLE;
          ready_nxt = link.ioSupplyStatus;
        end
      end
    endcase
    busy_nxt = (state_nxt != pwr_seq_pkg::HOST_IDLE);
    on_nxt   = link.ioSupplyStatus;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= pwr_seq_pkg::HOST_IDLE;
      cnt_r      <= '0;
      ponOe_r    <= 1'b0;
      rstOe_r    <= 1'b0;
      shut_r     <= 1'b0;
      cmdValid_r <= 1'b0;
      cmdSel_r   <= pwr_seq_pkg::CLK_SEL_FAST;
      cmdEn_r    <= 1'b0;
      busy_r     <= 1'b0;
      on_r       <= 1'b0;
      ready_r    <= 1'b0;
    end else if (ce) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      ponOe_r    <= ponOe_nxt;
      rstOe_r    <= rstOe_nxt;
      shut_r     <= shut_nxt;
      cmdValid_r <= cmdValid_nxt;
      cmdSel_r   <= cmdSel_nxt;
      cmdEn_r    <= cmdEn_nxt;
      busy_r     <= busy_nxt;
      on_r       <= on_nxt;
      ready_r    <= ready_nxt;
    end
  end

  // The request pins are only ever pulled low or released.
  assign link.powerOnRequestNOut = 1'b0;
  assign link.resetRequestNOut   = 1'b0;
  assign link.powerOnRequestNOe  = ponOe_r;
  assign link.resetRequestNOe    = rstOe_r;
  assign link.shutdownCommand    = shut_r;
  assign link.clkCmdValid        = cmdValid_r;
  assign link.clkCmdSel          = cmdSel_r;
  assign link.clkCmdEnable       = cmdEn_r;
  assign busy                    = busy_r;
  assign moduleOn                = on_r;
  assign moduleReady             = ready_r;

endmodule : power_request_host
`default_nettype wire

// *** pwr_link_sva.sv ***
// Concurrent checks on the power and reset link between host end and device end.
`include "pwr_seq_consts.svh"
`default_nettype none
module pwr_link_sva #(
  parameter logic [`CNT_W-1:0] PonAssertCyc = `PON_ASSERT_CYC,
  parameter logic [`CNT_W-1:0] RstAssertCyc = `RST_ASSERT_CYC
) (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic                  powerOnRequestNOut,
  input wire logic                  powerOnRequestNOe,
  input wire logic                  resetRequestNOut,
  input wire logic                  resetRequestNOe,
  input wire logic                  powerOnRequestN,
  input wire logic                  resetRequestN,
  input wire logic                  ioSupplyStatus,
  input wire logic                  fastClockOut,
  input wire logic                  slowClockOut,
  input wire logic                  shutdownCommand,
  input wire logic                  clkCmdValid,
  input wire pwr_seq_pkg::clk_sel_e clkCmdSel,
  input wire logic                  clkCmdEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`CNT_W-1:0] ponLow_r;
  logic [`CNT_W-1:0] rstLow_r;
  logic [`CNT_W-1:0] ponOe_r;
  logic [`CNT_W-1:0] rstOe_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Run lengths of low pins and of host pull-downs
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ponLow_r <= '0;
      rstLow_r <= '0;
      ponOe_r  <= '0;
      rstOe_r  <= '0;
    end else begin
      ponLow_r <= powerOnRequestN ? '0 : ponLow_r + 1'b1;
      rstLow_r <= resetRequestN ? '0 : rstLow_r + 1'b1;
      ponOe_r  <= powerOnRequestNOe ? ponOe_r + 1'b1 : '0;
      rstOe_r  <= resetRequestNOe ? rstOe_r + 1'b1 : '0;
    end
  end

  // ==========================================================================
  // Device end
  // ==========================================================================
  chk_pins_idle_high: assert property (!$past(sys_rst) && !powerOnRequestNOe
    && !resetRequestNOe |-> powerOnRequestN && resetRequestN) else $error("pin not pulled up");
  chk_pon_switch_on: assert property (ponLow_r == PonAssertCyc - 1'b1
    && !powerOnRequestN && !ioSupplyStatus |=> ioSupplyStatus) else $error("no switch-on");
  chk_rise_cause: assert property ($rose(ioSupplyStatus) |->
    ponLow_r >= PonAssertCyc || rstLow_r >= RstAssertCyc) else $error("status rose early");
  chk_fall_cause: assert property ($fell(ioSupplyStatus) |->
    rstLow_r >= RstAssertCyc || $past(shutdownCommand)) else $error("status fell wrongly");
  chk_reset_off: assert property (rstLow_r == RstAssertCyc - 1'b1 && !resetRequestN
    && powerOnRequestN |=> !ioSupplyStatus) else $error("reset did not power off");
  chk_reset_restart: assert property (rstLow_r == RstAssertCyc - 1'b1 && !resetRequestN
    && !powerOnRequestN |=> ioSupplyStatus) else $error("reset did not restart");
  chk_clocks_quiet: assert property (!ioSupplyStatus && !$past(ioSupplyStatus) |->
    !fastClockOut && !slowClockOut) else $error("clock runs while off");
  chk_fast_toggle: assert property (fastClockOut |=> !fastClockOut)
    else $error("fast clock held high");
  chk_fast_disable: assert property (clkCmdValid && clkCmdSel == pwr_seq_pkg::CLK_SEL_FAST
    && !clkCmdEnable |-> ##2 (!fastClockOut) [*4]) else $error("fast clock not stopped");

  // ==========================================================================
  // Host end
  // ==========================================================================
  chk_pon_hold: assert property ($fell(powerOnRequestNOe) && !$fell(resetRequestNOe) |->
    ponOe_r >= PonAssertCyc) else $error("power-on pull too short");
  chk_rst_hold: assert property ($fell(resetRequestNOe) |->
    rstOe_r >= RstAssertCyc) else $error("reset pull too short");
  chk_drive_low: assert property (powerOnRequestNOe || resetRequestNOe |->
    !powerOnRequestNOut && !resetRequestNOut) else $error("request pin driven high");

  cover property ($rose(ioSupplyStatus));
  cover property ($fell(ioSupplyStatus));
  cover property (clkCmdValid && clkCmdEnable);
endmodule : pwr_link_sva
`default_nettype wire

// *** module_power_reset_sequencer_tb.sv ***
// Self-checking bench: host and device joined, plus a device on a rule-breaking link.
`include "pwr_seq_consts.svh"
`default_nettype none
module module_power_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [`CNT_W-1:0] PonCyc = 26'h5;
  localparam logic [`CNT_W-1:0] RstCyc = 26'h4;
  localparam logic [`CNT_W-1:0] UpCyc  = 26'h28;
  localparam int SPon[6] = '{1, 1, 1, 0, 1, 0};
  localparam int SRst[6] = '{0, 0, 0, 1, 1, 1};
  localparam int SLen[6] = '{PonCyc - 1, PonCyc, 20, RstCyc - 1, RstCyc, RstCyc};
  localparam int SExp[6] = '{0, 1, 1, 1, 1, 0};
  localparam int SClr[6] = '{0, 0, 0, 0, 1, 1};
  logic sys_clk, sys_rst, ce, mainSupplyOk, alwaysOnSupplyOk, expOn, fastEn, slowEn;
  logic powerOnStart, resetStart, resetRestart, shutdownStart, clkCmdStart, clkEnable;
  logic busy, moduleOn, moduleReady, coreRun, memoryClear, poweredUp;
  logic coreRun2, memoryClear2, poweredUp2;
  pwr_seq_pkg::clk_sel_e clkSel;
  int n_errors, checked, seed, clears, clears2, nf, ns;
  pwr_link_if link ();
  pwr_link_if link2 ();

  module_power_reset_sequencer #(.PonAssertCyc(PonCyc), .RstAssertCyc(RstCyc),
    .PowerUpCyc(UpCyc)) module_power_reset_sequencer_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .ce(ce), .mainSupplyOk(mainSupplyOk), .alwaysOnSupplyOk(alwaysOnSupplyOk),
    .link(link), .coreRun(coreRun), .memoryClear(memoryClear), .poweredUp(poweredUp));
  module_power_reset_sequencer #(.PonAssertCyc(PonCyc), .RstAssertCyc(RstCyc),
    .PowerUpCyc(UpCyc)) module_power_reset_sequencer_inst2 (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .ce(ce), .mainSupplyOk(mainSupplyOk), .alwaysOnSupplyOk(alwaysOnSupplyOk),
    .link(link2), .coreRun(coreRun2), .memoryClear(memoryClear2), .poweredUp(poweredUp2));
  power_request_host #(.PonAssertCyc(PonCyc), .RstAssertCyc(RstCyc), .PowerUpCyc(UpCyc))
    power_request_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .powerOnStart(powerOnStart), .resetStart(resetStart), .resetRestart(resetRestart),
    .shutdownStart(shutdownStart), .clkCmdStart(clkCmdStart), .clkSel(clkSel),
    .clkEnable(clkEnable), .link(link), .busy(busy), .moduleOn(moduleOn),
    .moduleReady(moduleReady));
  pwr_link_sva #(.PonAssertCyc(PonCyc), .RstAssertCyc(RstCyc)) pwr_link_sva_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .powerOnRequestNOut(link.powerOnRequestNOut),
    .powerOnRequestNOe(link.powerOnRequestNOe), .resetRequestNOut(link.resetRequestNOut),
    .resetRequestNOe(link.resetRequestNOe), .powerOnRequestN(link.powerOnRequestN),
    .resetRequestN(link.resetRequestN), .ioSupplyStatus(link.ioSupplyStatus),
    .fastClockOut(link.fastClockOut), .slowClockOut(link.slowClockOut),
    .shutdownCommand(link.shutdownCommand), .clkCmdValid(link.clkCmdValid),
    .clkCmdSel(link.clkCmdSel), .clkCmdEnable(link.clkCmdEnable));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (memoryClear === 1'b1) clears++;
    if (memoryClear2 === 1'b1) clears2++;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic nextOn(int op, logic on);
    return (op < 2) ? 1'b1 : (op < 4) ? 1'b0 : on;
  endfunction : nextOn

  task automatic countRises(int cyc);
    logic pf, ps;
    pf = link.fastClockOut;
    ps = link.slowClockOut;
    nf = 0;
    ns = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      if (link.fastClockOut === 1'b1 && pf === 1'b0) nf++;
      if (link.slowClockOut === 1'b1 && ps === 1'b0) ns++;
      pf = link.fastClockOut;
      ps = link.slowClockOut;
    end
  endtask : countRises

  // Op codes: 0 power-on, 1 restart, 2 reset-off, 3 shutdown, 4 clock command.
  task automatic doOp(int op, logic [1:0] r);
    int i;
    clears = 0;
    @(negedge sys_clk);
    powerOnStart = (op == 0);
    resetStart = (op == 1 || op == 2);
    resetRestart = (op == 1);
    shutdownStart = (op == 3);
    clkCmdStart = (op == 4);
    clkSel = pwr_seq_pkg::clk_sel_e'(r[0]);
    clkEnable = r[1];
    if (op == 4 && expOn && r[0]) slowEn = r[1];
    if (op == 4 && expOn && !r[0]) fastEn = r[1];
    expOn = nextOn(op, expOn);
    @(negedge sys_clk);
    {powerOnStart, resetStart, shutdownStart, clkCmdStart} = 4'h0;
    for (i = 0; i < 500 && busy !== 1'b0; i++) @(negedge sys_clk);
    check("idle", 8'(i < 500), 8'h1);
    repeat (12) @(negedge sys_clk);
    check("status", 8'(moduleOn), 8'(expOn));
    check("ready", 8'(moduleReady), 8'(expOn));
    check("poweredUp", 8'(poweredUp), 8'(expOn));
    check("coreRun", 8'(coreRun), 8'(expOn));
    check("clears", 8'(clears), 8'(op == 1 || op == 2));
    countRises(8);
    check("fastRises", 8'(nf), (expOn && fastEn) ? 8'h4 : 8'h0);
    $display("op %0d done, errors %0d", op, n_errors);
  endtask : doOp

  task automatic pull2(int pon, int rstp, int cyc);
    @(negedge sys_clk);
    link2.powerOnRequestNOe = 1'(pon);
    link2.resetRequestNOe = 1'(rstp);
    repeat (cyc) @(negedge sys_clk);
    {link2.powerOnRequestNOe, link2.resetRequestNOe} = 2'h0;
    repeat (UpCyc + 8) @(negedge sys_clk);
  endtask : pull2

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 564;
    {n_errors, checked, clears, clears2} = '0;
    {ce, mainSupplyOk, alwaysOnSupplyOk, sys_rst} = 4'hF;
    {powerOnStart, resetStart, resetRestart, shutdownStart, clkCmdStart, clkEnable} = 6'h0;
    {expOn, fastEn, slowEn} = 3'h0;
    clkSel = pwr_seq_pkg::CLK_SEL_FAST;
    {link2.powerOnRequestNOut, link2.powerOnRequestNOe, link2.resetRequestNOut} = 3'h0;
    {link2.resetRequestNOe, link2.shutdownCommand, link2.clkCmdValid} = 3'h0;
    link2.clkCmdSel = pwr_seq_pkg::CLK_SEL_FAST;
    link2.clkCmdEnable = 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("ponIdle", 8'(link2.powerOnRequestN), 8'h1);
    for (int k = 0; k < 6; k++) begin
      clears2 = 0;
      pull2(SPon[k], SRst[k], SLen[k]);
      check("status2", 8'(link2.ioSupplyStatus), 8'(SExp[k]));
      check("up2", 8'(poweredUp2 && coreRun2), 8'(SExp[k]));
      check("clear2", 8'(clears2), 8'(SClr[k]));
      $display("link2 case %0d done", k);
    end
    ce = 1'b0;
    pull2(1, 0, PonCyc);
    ce = 1'b1;
    check("ceFreeze", 8'(link2.ioSupplyStatus), 8'h0);
    $display("clock enable test done");
    doOp(0, 2'h0);
    doOp(4, 2'h2);
    doOp(1, 2'h0);
    doOp(4, 2'h0);
    doOp(3, 2'h0);
    doOp(1, 2'h0);
    doOp(2, 2'h0);
    for (int k = 0; k < 40; k++) doOp($unsigned($random(seed)) % 5, 2'($random(seed)));
    doOp(0, 2'h0);
    doOp(4, 2'h3);
    countRises(2000);
    check("slowRises", 8'(ns == 2 || ns == 3), 8'h1);
    $display("slow clock test done");
    finish_test();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule : module_power_reset_sequencer_tb
`default_nettype wire
